//--- rtl/pdt_timer.sv
// Purpose : 8-bit down counter timer behind a 7-bit prescaler, Wishbone slave.
// Assumes : Single clock mclk, synchronous active-low reset rst_n.
// Notes   : Ack one cycle after request; unmapped addresses ack and read zero.
//
// Behaviour
// - Count write beats simultaneous zero decrement
// - Counter and prescaler readable at any time
// - Zero flag bit 7 set on zero
// - Interrupt when enable bit 6 and flag
// - Run bit low holds prescaler 7Fh, stopped
// - Run bit high lets prescaler count down
// - Select bits choose divide 1 to 128
// - Counter is 8-bit read/write value
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps

module pdt_timer
    import pdt_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [11:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic             irq_o
);

    // ********************************************************************
    // State
    // ********************************************************************
    pdt_state_t st_ff;
    pdt_state_t nxt_st;

    logic        req;
    logic        wr_take;
    logic [9:0]  idx;
    logic        wr_psc;
    logic        wr_cnt;
    logic        wr_tsc;
    logic        wr_ien;
    logic        wr_clr;
    logic [6:0]  div_mask;
    logic        tick;
    logic        zero_event;
    logic [7:0]  tsc_view;
    logic [31:0] rd_mux;

    assign req     = cyc_i & stb_i;
    assign wr_take = req & we_i & sel_i[0] & st_ff.ack;
    assign idx     = adr_i[11:2];
    assign wr_psc  = wr_take & (idx == PDT_IDX_PRESCALER);
    assign wr_cnt  = wr_take & (idx == PDT_IDX_COUNT);
    assign wr_tsc  = wr_take & (idx == PDT_IDX_STATCTRL);
    assign wr_ien  = wr_take & (idx == PDT_IDX_IRQ_EN);
    assign wr_clr  = wr_take & (idx == PDT_IDX_IRQ_CLR);

    // ********************************************************************
    // Prescaler tick
    // ********************************************************************
    // Division select mask
    assign div_mask = 7'((8'h01 << st_ff.div_select) - 8'h01);
    assign tick     = st_ff.prescaler_init_run & ((st_ff.prescaler & div_mask) == 7'h00);
    assign zero_event = tick & (st_ff.count == PDT_COUNT_ONE);

    assign tsc_view = {st_ff.zero_reached_flag, st_ff.timer_irq_enable,
                       st_ff.reserved_set_one, st_ff.spare_bit4,
                       st_ff.prescaler_init_run, st_ff.div_select};

    // ********************************************************************
    // Read mux
    // ********************************************************************
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (idx)
            PDT_IDX_PRESCALER: rd_mux = {25'h0000000, st_ff.prescaler};
            PDT_IDX_COUNT:     rd_mux = {24'h000000, st_ff.count};
            PDT_IDX_STATCTRL:  rd_mux = {24'h000000, tsc_view};
            PDT_IDX_IRQ_STAT:  rd_mux = {31'h00000000, st_ff.irq_status};
            PDT_IDX_IRQ_EN:    rd_mux = {31'h00000000, st_ff.irq_enable};
            default:           rd_mux = 32'h0000_0000;
        endcase
    end

    // ********************************************************************
    // Next state
    // ********************************************************************
    always_comb begin
        nxt_st = st_ff;

        nxt_st.ack = req & ~st_ff.ack;
        if (req & ~st_ff.ack) begin
            nxt_st.rdata = rd_mux;
        end

        if (!st_ff.prescaler_init_run) begin
            nxt_st.prescaler = PDT_PRESCALER_INIT;
        end else begin
            nxt_st.prescaler = st_ff.prescaler - 7'h01;
        end
        // A stopped prescaler ignores writes and stays at 7Fh
        if (wr_psc & st_ff.prescaler_init_run) begin
            nxt_st.prescaler = dat_i[6:0];
        end

        if (tick) begin
            nxt_st.count = st_ff.count - 8'h01;
        end
        if (wr_cnt) begin
            nxt_st.count = dat_i[7:0];
        end

        if (wr_tsc) begin
            nxt_st.zero_reached_flag  = dat_i[PDT_BIT_ZERO];
            nxt_st.timer_irq_enable   = dat_i[PDT_BIT_IRQEN];
            nxt_st.reserved_set_one   = dat_i[PDT_BIT_RSV1];
            nxt_st.spare_bit4         = dat_i[PDT_BIT_RSV1-1];
            nxt_st.prescaler_init_run = dat_i[PDT_BIT_RUN];
            nxt_st.div_select         = dat_i[PDT_DIV_LSB +: 3];
            if (!dat_i[PDT_BIT_RUN]) begin
                nxt_st.prescaler = PDT_PRESCALER_INIT;
            end
        end

        if (zero_event & ~wr_cnt) begin
            nxt_st.zero_reached_flag = 1'b1;
            nxt_st.irq_status[PDT_BIT_EV_ZERO] = 1'b1;
        end

        if (wr_ien) begin
            nxt_st.irq_enable = dat_i[0:0];
        end
        if (wr_clr & dat_i[PDT_BIT_EV_ZERO] & ~(zero_event & ~wr_cnt)) begin
            nxt_st.irq_status[PDT_BIT_EV_ZERO] = 1'b0;
        end
    end

    // ********************************************************************
    // Registers
    // ********************************************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_ff.prescaler          <= PDT_PRESCALER_INIT;
            st_ff.count              <= PDT_COUNT_RST;
            st_ff.zero_reached_flag  <= PDT_STATCTRL_RST[PDT_BIT_ZERO];
            st_ff.timer_irq_enable   <= PDT_STATCTRL_RST[PDT_BIT_IRQEN];
            st_ff.reserved_set_one   <= PDT_STATCTRL_RST[PDT_BIT_RSV1];
            st_ff.spare_bit4         <= PDT_STATCTRL_RST[PDT_BIT_RSV1-1];
            st_ff.prescaler_init_run <= PDT_STATCTRL_RST[PDT_BIT_RUN];
            st_ff.div_select         <= PDT_STATCTRL_RST[PDT_DIV_LSB +: 3];
            st_ff.irq_status         <= PDT_IRQ_RST;
            st_ff.irq_enable         <= PDT_IRQ_RST;
            st_ff.ack                <= 1'b0;
            st_ff.rdata              <= 32'h0000_0000;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign dat_o = st_ff.rdata;
    assign ack_o = st_ff.ack;
    assign irq_o = (st_ff.zero_reached_flag & st_ff.timer_irq_enable)
                 | |(st_ff.irq_status & st_ff.irq_enable);

endmodule

//--- rtl/pdt_pkg.sv
// Purpose : Shared constants and types of the prescaled down counter timer.
// Assumes : Classic Wishbone slave, 32-bit data, byte address = 4 * register index.
// Notes   : Register indices are kept as printed; the bus decodes adr[11:2].
package pdt_pkg;

    // ********************************************************************
    // Register map
    // ********************************************************************
    localparam logic [9:0] PDT_IDX_PRESCALER = 10'h0d2;
    localparam logic [9:0] PDT_IDX_COUNT     = 10'h0d3;
    localparam logic [9:0] PDT_IDX_STATCTRL  = 10'h0d4;
    localparam logic [9:0] PDT_IDX_IRQ_STAT  = 10'h0d5;
    localparam logic [9:0] PDT_IDX_IRQ_EN    = 10'h0d6;
    localparam logic [9:0] PDT_IDX_IRQ_CLR   = 10'h0d7;

    // ********************************************************************
    // Status/control field positions
    // ********************************************************************
    localparam int PDT_BIT_ZERO   = 7;
    localparam int PDT_BIT_IRQEN  = 6;
    localparam int PDT_BIT_RSV1   = 5;
    localparam int PDT_BIT_RUN    = 3;
    localparam int PDT_DIV_LSB    = 0;
    localparam int PDT_BIT_EV_ZERO = 0;

    // ********************************************************************
    // Reset values and the count-one compare value
    // ********************************************************************
    localparam logic [6:0] PDT_PRESCALER_INIT = 7'h7f;
    localparam logic [7:0] PDT_COUNT_RST      = 8'h00;
    localparam logic [7:0] PDT_STATCTRL_RST   = 8'h00;
    localparam logic [0:0] PDT_IRQ_RST        = 1'h0;
    localparam logic [7:0] PDT_COUNT_ONE      = 8'h01;

    // ********************************************************************
    // Module state
    // ********************************************************************
    typedef struct packed {
        logic [6:0]  prescaler;
        logic [7:0]  count;
        logic        zero_reached_flag;
        logic        timer_irq_enable;
        logic        reserved_set_one;
        logic        spare_bit4;
        logic        prescaler_init_run;
        logic [2:0]  div_select;
        logic [0:0]  irq_status;
        logic [0:0]  irq_enable;
        logic        ack;
        logic [31:0] rdata;
    } pdt_state_t;

endpackage

//--- bench/pdt_timer_chk.sv
// Purpose: Bus and timer property checks.
// Assumes: Master holds a request until ack.
// Notes: Shadows follow status and enable writes.
`timescale 1ns/1ps
module pdt_timer_chk
    import pdt_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [11:0] adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        irq_o
);
    logic run_ff, ie_ff, en_ff;
    wire logic [9:0] ix = adr_i[11:2];
    wire logic wr = ack_o && we_i && sel_i[0];
    wire logic rd = ack_o && !we_i;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            run_ff <= 1'b0;
            ie_ff  <= 1'b0;
            en_ff  <= 1'b0;
        end else if (wr && ix == PDT_IDX_STATCTRL) begin
            run_ff <= dat_i[PDT_BIT_RUN];
            ie_ff  <= dat_i[PDT_BIT_IRQEN];
        end else if (wr && ix == PDT_IDX_IRQ_EN) begin
            en_ff <= dat_i[0];
        end
    end
    chk_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack too long");
    chk_ack_latency: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack late");
    chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    chk_psc_top: assert property (rd && ix == PDT_IDX_PRESCALER |-> dat_o[31:7] == '0)
        else $error("prescaler bit 7 set");
    chk_read_byte: assert property (rd |-> dat_o[31:8] == '0)
        else $error("read above byte 0");
    chk_psc_held: assert property (rd && ix == PDT_IDX_PRESCALER && !run_ff
        |-> dat_o[7:0] == 8'h7f) else $error("stopped prescaler moved");
    chk_irq_flag: assert property (rd && ix == PDT_IDX_STATCTRL && dat_o[7] && dat_o[6]
        |-> irq_o) else $error("irq missing");
    chk_irq_none: assert property (!ie_ff && !en_ff |-> !irq_o)
        else $error("irq while disabled");
    cov_irq: cover property ($rose(irq_o));
    cov_flag: cover property (rd && ix == PDT_IDX_STATCTRL && dat_o[7]);
    cov_cnt_wr: cover property (wr && ix == PDT_IDX_COUNT);
endmodule
bind pdt_timer pdt_timer_chk u_chk (.mclk(mclk), .rst_n(rst_n), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .irq_o(irq_o));

//--- bench/pdt_timer_tb.sv
// Purpose: Self-checking bench of the timer.
// Assumes: Ack one cycle after a request.
// Notes: Each scenario checks its own reads.
`timescale 1ns/1ps
module pdt_timer_tb
    import pdt_pkg::*;
;
    logic mclk = 1'b0, rst_n = 1'b0, cyc = 1'b0, we = 1'b0;
    logic [11:0] adr = '0;
    logic [31:0] wd = '0, rd;
    wire logic [31:0] dat_o;
    wire logic ack, irq;
    int n_fail = 0, total_checks = 0, cycles = 0;
    always #2.5 mclk = ~mclk;
    pdt_timer dut (.mclk(mclk), .rst_n(rst_n), .cyc_i(cyc), .stb_i(cyc), .we_i(we),
        .adr_i(adr), .sel_i(4'hf), .dat_i(wd), .dat_o(dat_o), .ack_o(ack), .irq_o(irq));
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One classic cycle, held until ack is sampled
    task automatic xfer(logic w, logic [9:0] ix, logic [31:0] d);
        @(posedge mclk);
        cyc <= 1'b1;
        we <= w;
        adr <= {ix, 2'b00};
        wd <= d;
        do @(posedge mclk); while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
    endtask
    task automatic t_reset();
        xfer(0, PDT_IDX_PRESCALER, '0);
        check("psc", rd, 32'h7f);
        xfer(1, PDT_IDX_COUNT, 32'ha5);
        repeat (20) @(posedge mclk);
        xfer(0, PDT_IDX_COUNT, '0);
        check("count", rd, 32'ha5);
        xfer(0, 10'h3ff, '0);
        check("unmapped", rd, 32'h0);
    endtask
    // Exactly 128 edges between the two count samples
    task automatic t_divs();
        logic [7:0] a;
        for (int s = 0; s < 8; s++) begin
            xfer(1, PDT_IDX_STATCTRL, 32'h20 | s);
            xfer(1, PDT_IDX_COUNT, '0);
            xfer(1, PDT_IDX_STATCTRL, 32'h28 | s);
            xfer(0, PDT_IDX_COUNT, '0);
            a = rd[7:0];
            repeat (125) @(posedge mclk);
            xfer(0, PDT_IDX_COUNT, '0);
            check("ticks", rd, {24'h0, a - 8'(128 >> s)});
        end
    endtask
    task automatic t_zero();
        xfer(1, PDT_IDX_STATCTRL, 32'h20);
        xfer(1, PDT_IDX_IRQ_CLR, 32'h1);
        xfer(1, PDT_IDX_COUNT, 32'h3);
        xfer(1, PDT_IDX_STATCTRL, 32'h28);
        repeat (8) @(posedge mclk);
        xfer(0, PDT_IDX_STATCTRL, '0);
        check("flag", rd, 32'ha8);
        check("masked", {31'h0, irq}, 32'h0);
        xfer(1, PDT_IDX_STATCTRL, 32'he8);
        xfer(0, PDT_IDX_STATCTRL, '0);
        check("flag and enable", rd, 32'he8);
        check("irq on", {31'h0, irq}, 32'h1);
        xfer(1, PDT_IDX_STATCTRL, 32'h68);
        xfer(0, PDT_IDX_IRQ_STAT, '0);
        check("event", {rd[31:1], irq}, 32'h0);
        check("sticky", rd, 32'h1);
        xfer(1, PDT_IDX_IRQ_EN, 32'h1);
        xfer(0, PDT_IDX_IRQ_EN, '0);
        check("irq en", {rd[31:1], irq}, 32'h1);
        xfer(1, PDT_IDX_IRQ_CLR, 32'h1);
        xfer(0, PDT_IDX_IRQ_STAT, '0);
        check("cleared", {rd[31:1], irq}, 32'h0);
    endtask
    // Count write lands on the edge of the 01 to 00 step
    task automatic t_race();
        xfer(1, PDT_IDX_STATCTRL, 32'h27);
        xfer(1, PDT_IDX_COUNT, 32'h1);
        xfer(1, PDT_IDX_STATCTRL, 32'h2f);
        do xfer(0, PDT_IDX_PRESCALER, '0); while (rd < 8);
        repeat (rd[6:0] - 4) @(posedge mclk);
        xfer(1, PDT_IDX_COUNT, 32'h40);
        xfer(0, PDT_IDX_COUNT, '0);
        check("kept", rd, 32'h40);
        xfer(0, PDT_IDX_STATCTRL, '0);
        check("no flag", rd, 32'h2f);
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            print_verdict();
        end
    end
    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_divs();
        t_zero();
        t_race();
        print_verdict();
    end
endmodule
